// [src/scp_consts.svh]
// constants for the serial configuration memory readout block
// assumes: included by bare name from the package and the design file
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH

`define SCP_WORD_BITS   32
`define SCP_DEF_WORDS   2048
`define SCP_FIFO_DEPTH  16
`define SCP_ENTRY_EDGES 2
`define SCP_LAST_BIT    5'h1F
`define SCP_POL_LOW     32'h0000_0000
`define SCP_PIN_RST     5'h08

`endif

// [src/scp_pkg.sv]
// types shared by the serial configuration memory readout block
// assumes: scp_consts.svh sits beside this file
`include "scp_consts.svh"

package scp_pkg;

  // filtered pin levels, one bit each
  typedef struct packed {
    logic promClk;
    logic chipEnable_n;
    logic resetOe;
    logic vppHigh;
    logic dataIn;
  } scp_pins_t;

  // cascade output sequencing after end of array
  typedef enum logic [1:0] {
    CEO_IDLE,
    CEO_LOW,
    CEO_FOLLOW
  } scp_ceo_t;

endpackage

// [src/scp_readout.sv]
// serial configuration memory readout: word FIFO and device top
// assumes: pins arrive asynchronous to clk; promClk far slower than clk
`timescale 1ns/1ps
`default_nettype none
`include "scp_consts.svh"

module scp_fifo #(
  parameter int W = `SCP_WORD_BITS,
  parameter int D = `SCP_FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         flush,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int PW = $clog2(D);

  logic [W-1:0] store [0:D-1];
  logic [PW:0]  wrPtr;
  logic [PW:0]  rdPtr;
  wire          push = inValid && inReady;
  wire          pop  = outValid && outReady;

  // full when pointers differ only in the wrap bit
  assign inReady  = !flush && !((wrPtr[PW] != rdPtr[PW]) && (wrPtr[PW-1:0] == rdPtr[PW-1:0]));
  assign outValid = !flush && (wrPtr != rdPtr);
  assign outData  = store[rdPtr[PW-1:0]];

  // pointers; flush empties without touching storage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
    end
    else if (flush)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
    end
    else
    begin
      if (push) wrPtr <= wrPtr + 1'b1;
      if (pop)  rdPtr <= rdPtr + 1'b1;
    end
  end

  // storage words need no reset
  always_ff @(posedge clk)
  begin
    if (push) store[wrPtr[PW-1:0]] <= inData;
  end
endmodule // scp_fifo

// How it works
// [RULE_01] after last bit: cascade low, data released
// [RULE_02] chip select low turns data driver on
// [RULE_03] reset level clears address and bit counters
// [RULE_04] reset pin may be grounded to hold position
// [RULE_05] chip select high means low-power standby
// [RULE_06] standby keeps data released regardless of enable
// [RULE_07] two high-supply edges then one normal: programming
// [RULE_08] programmer exits with both selects low first
// [RULE_09] overflow word picks reset polarity
// [RULE_10] unprogrammed part uses active-high reset
// [RULE_11] driver on only with both inputs active
// [RULE_12] clock edges advance counters, reading and programming
// [RULE_13] chip select high freezes counters
// [RULE_14] cascade out low, then follows, then high
// [RULE_15] one bit per edge, ascending, 32-bit words
module scp_readout #(
  parameter int WORDS = `SCP_DEF_WORDS
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic promClk,
  input  wire logic chipEnable_n,
  input  wire logic resetOe,
  input  wire logic vppHigh,
  input  wire logic dataIn,
  output logic      dataOut,
  output logic      dataOe_n,
  output logic      cascade_enable_out_n,
  output logic      lowPower,
  output logic      progActive
);
  localparam int              AW        = $clog2(WORDS + 1);
  localparam logic [AW-1:0]   LAST_WORD = AW'(WORDS - 1);
  localparam logic [AW-1:0]   OVF_WORD  = AW'(WORDS);
  // every check below samples on clk and rests during reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic [`SCP_WORD_BITS-1:0] mem [0:WORDS];
  scp_pkg::scp_pins_t        s1, s2, s3, pins;
  logic                      clkPrev;
  logic                      polHigh;
  logic                      progMode;
  logic [1:0]                hiCnt;
  logic [AW-1:0]             progAddr;
  logic [4:0]                progBits;
  logic [`SCP_WORD_BITS-1:0] progShift;
  logic [AW-1:0]             fetchAddr;
  logic [AW-1:0]             wordIdx;
  logic [4:0]                bitIdx;
  logic [`SCP_WORD_BITS-1:0] curWord;
  logic                      haveWord;
  logic                      eoa;
  scp_pkg::scp_ceo_t         ceoSt;
  logic                      fInReady, fOutValid;
  logic [`SCP_WORD_BITS-1:0] fOutData;
  // three-flop pin synchroniser; a change counts once s2 and s3 agree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1   <= `SCP_PIN_RST;
      s2   <= `SCP_PIN_RST;
      s3   <= `SCP_PIN_RST;
      pins <= `SCP_PIN_RST;
    end
    else
    begin
      s1   <= {promClk, chipEnable_n, resetOe, vppHigh, dataIn};
      s2   <= s1;
      s3   <= s2;
      pins <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & pins);
    end
  end
  // decoded pin conditions
  wire pinEdge   = pins.promClk && !clkPrev;
  wire ceN       = pins.chipEnable_n;
  wire resetLvl  = polHigh ? pins.resetOe : !pins.resetOe;    // [RULE_09]
  wire oeAct     = !resetLvl;
  wire readOn    = !ceN && !resetLvl && !progMode;
  wire lastBit   = (bitIdx == `SCP_LAST_BIT) && (wordIdx == LAST_WORD);
  wire flush     = resetLvl || progMode;
  wire progShiftEdge = progMode && pinEdge && ceN && pins.resetOe;
  wire progAddrEdge  = progMode && pinEdge && ceN && !pins.resetOe;
  wire [`SCP_WORD_BITS-1:0] nextShift = {pins.dataIn, progShift[`SCP_WORD_BITS-1:1]};
  wire wrEn      = progShiftEdge && (progBits == `SCP_LAST_BIT);
  wire entryEdge = !progMode && pinEdge && ceN && pins.resetOe;
  wire fetchOn   = (fetchAddr != OVF_WORD);
  // standby follows chip select directly
  assign lowPower   = ceN;                                     // [RULE_05]
  assign progActive = progMode;
  // driver only when selected, enabled, not past the array
  assign dataOe_n   = !(readOn && oeAct && !eoa && haveWord);  // [RULE_02] [RULE_06] [RULE_11]
  // in programming mode the cascade pin reports reset polarity
  assign cascade_enable_out_n = progMode ? polHigh :
                                (ceoSt == scp_pkg::CEO_LOW) ? 1'b0 :
                                (ceoSt == scp_pkg::CEO_FOLLOW) ? ceN : 1'b1; // [RULE_14]
  // prefetch queue keeps the bit stream fed from the array
  scp_fifo #(
    .W (`SCP_WORD_BITS),
    .D (`SCP_FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .flush    (flush),
    .inValid  (fetchOn),
    .inReady  (fInReady),
    .inData   (mem[fetchAddr]),
    .outValid (fOutValid),
    .outReady (!haveWord && !flush),
    .outData  (fOutData)
  );
  // fetch address stalls while the queue is full
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fetchAddr <= '0;
    else if (flush)
      fetchAddr <= '0;
    else if (fetchOn && fInReady)
      fetchAddr <= fetchAddr + 1'b1;
  end
  // read counters; a grounded reset pin never clears them while reset polarity is active high
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clkPrev  <= 1'b0;
      wordIdx  <= '0;
      bitIdx   <= '0;
      curWord  <= '0;
      haveWord <= 1'b0;
      eoa      <= 1'b0;
      dataOut  <= 1'b0;
    end
    else
    begin
      clkPrev <= pins.promClk;
      dataOut <= curWord[bitIdx];                              // [RULE_15]
      if (flush)
      begin
        wordIdx  <= '0;                                        // [RULE_03] [RULE_04]
        bitIdx   <= '0;
        haveWord <= 1'b0;
        eoa      <= 1'b0;
      end
      else if (!haveWord && fOutValid)
      begin
        curWord  <= fOutData;
        haveWord <= 1'b1;
      end
      else if (pinEdge && readOn && haveWord && !eoa)          // [RULE_13]
      begin
        if (lastBit)
          eoa <= 1'b1;                                         // [RULE_01]
        else if (bitIdx == `SCP_LAST_BIT)
        begin
          bitIdx   <= '0;
          wordIdx  <= wordIdx + 1'b1;                          // [RULE_12]
          haveWord <= 1'b0;
        end
        else
          bitIdx <= bitIdx + 1'b1;                             // [RULE_12]
      end
    end
  end
  // cascade sequencing; idle holds high until the array ends again
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ceoSt <= scp_pkg::CEO_IDLE;
    else if (progMode)
      ceoSt <= scp_pkg::CEO_IDLE;
    else
      unique case (ceoSt)
        scp_pkg::CEO_IDLE:
          if (pinEdge && readOn && haveWord && !eoa && lastBit)
            ceoSt <= scp_pkg::CEO_LOW;                         // [RULE_01]
        scp_pkg::CEO_LOW:
          if (!oeAct)
            ceoSt <= scp_pkg::CEO_IDLE;
          else if (ceN)
            ceoSt <= scp_pkg::CEO_FOLLOW;                      // [RULE_14]
        scp_pkg::CEO_FOLLOW:
          if (!oeAct)
            ceoSt <= scp_pkg::CEO_IDLE;                        // [RULE_14]
      endcase
  end
  // programming entry, word shift-in, address step and exit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      progMode  <= 1'b0;
      hiCnt     <= '0;
      progAddr  <= '0;
      progBits  <= '0;
      progShift <= '0;
      polHigh   <= 1'b1;                                       // [RULE_10]
    end
    else if (progMode)
    begin
      // exit needs both selects low; power removal is the programmer's job
      if (!ceN && !pins.resetOe)
        progMode <= 1'b0;                                      // [RULE_08]
      if (progShiftEdge)
      begin
        progShift <= nextShift;
        progBits  <= progBits + 1'b1;
      end
      if (wrEn && (progAddr == OVF_WORD))
        polHigh <= (nextShift != `SCP_POL_LOW);                // [RULE_09]
      if (progAddrEdge)
      begin
        progAddr <= progAddr + 1'b1;                           // [RULE_12]
        progBits <= '0;
      end
    end
    else if (pinEdge)
    begin
      if (!entryEdge)
        hiCnt <= '0;
      else if (pins.vppHigh)
        hiCnt <= (hiCnt == 2'(`SCP_ENTRY_EDGES)) ? hiCnt : hiCnt + 1'b1;
      else if (hiCnt == 2'(`SCP_ENTRY_EDGES))
      begin
        progMode <= 1'b1;                                      // [RULE_07]
        hiCnt    <= '0;
        progAddr <= '0;
        progBits <= '0;
      end
      else
        hiCnt <= '0;
    end
  end
  // array writes; overflow word lives one past the last address
  always_ff @(posedge clk)
  begin
    if (wrEn && (progAddr <= OVF_WORD))
      mem[progAddr] <= nextShift;
  end
  // guards on read path, cascade and programming; clock and reset from the defaults
  a_eoa_release: assert property ( // [RULE_01]
    (pinEdge && readOn && haveWord && !eoa && lastBit) |=> (eoa && dataOe_n && !cascade_enable_out_n))
    else $error("end of array did not release data and lower cascade");
  a_drive_start: assert property ( // [RULE_02]
    (!ceN && oeAct && !eoa && !progMode && haveWord) |-> !dataOe_n)
    else $error("selected device not driving data");
  a_counter_clear: assert property ( // [RULE_03]
    (resetLvl && !progMode) |=> (wordIdx == '0 && bitIdx == '0 && !eoa))
    else $error("reset level did not clear counters");
  a_standby_hiz: assert property ( // [RULE_06]
    ceN |-> (dataOe_n && lowPower))
    else $error("standby with data driven");
  a_oe_gate: assert property ( // [RULE_11]
    !dataOe_n |-> (!ceN && oeAct && !progMode))
    else $error("data driven without both enables");
  a_bit_step: assert property ( // [RULE_12]
    (pinEdge && readOn && haveWord && !eoa && bitIdx != `SCP_LAST_BIT) |=> bitIdx == 5'($past(bitIdx) + 1))
    else $error("bit counter did not advance");
  a_freeze_ce: assert property ( // [RULE_13]
    (ceN && !resetLvl && !progMode) |=> ($stable(wordIdx) && $stable(bitIdx)))
    else $error("counters moved while deselected");
  a_prog_entry: assert property ( // [RULE_07]
    (entryEdge && !pins.vppHigh && hiCnt == 2'(`SCP_ENTRY_EDGES)) |=> progMode)
    else $error("programming entry not recognised");
  a_pol_write: assert property ( // [RULE_09]
    (wrEn && progAddr == OVF_WORD) |=> (polHigh == ($past(nextShift) != `SCP_POL_LOW)))
    else $error("overflow word did not set polarity");
  a_ceo_follow: assert property ( // [RULE_14]
    (ceoSt == scp_pkg::CEO_FOLLOW && !progMode) |-> (cascade_enable_out_n == ceN))
    else $error("cascade output not following chip select");
endmodule // scp_readout

`default_nettype wire

// [verification/scp_cfg_master.sv]
// far-side model: configuration master driving the memory pins
// assumes: bench clk; every pin phase held five clk for the pin filter
`timescale 1ns/1ps
`default_nettype none
module scp_cfg_master (
  input  wire logic clk,
  output logic      promClk,
  output logic      chipEnable_n,
  output logic      resetOe,
  output logic      vppHigh,
  output logic      dataIn
);
  // idle: deselected, supply normal, pin clock parked low
  initial
  begin
    promClk = 1'b0;
    chipEnable_n = 1'b1;
    resetOe = 1'b1;
    vppHigh = 1'b0;
    dataIn = 1'b0;
  end

  // one pin clock period; data set up before the rising edge
  task automatic step(input logic d);
    dataIn = d;
    repeat (5) @(posedge clk);
    #1 promClk = 1'b1;
    repeat (5) @(posedge clk);
    #1 promClk = 1'b0;
  endtask

  // level pins change only while the pin clock rests
  task automatic pins(input logic ce, input logic oe, input logic vpp);
    repeat (5) @(posedge clk);
    #1 chipEnable_n = ce;
    resetOe = oe;
    vppHigh = vpp;
  endtask

  // entry: two high-supply edges, then one at normal supply
  task automatic enter_prog();
    pins(1'b1, 1'b1, 1'b1);
    step(1'b0);
    step(1'b0);
    pins(1'b1, 1'b1, 1'b0);
    step(1'b0);
  endtask

  // one word LSB first, then advance the word address
  task automatic write_word(input logic [31:0] w);
    pins(1'b1, 1'b1, 1'b0);
    for (int i = 0; i < 32; i++)
      step(w[i]);
    pins(1'b1, 1'b0, 1'b0);
    step(1'b0);
  endtask

  // exit: both selects low before any power removal
  task automatic exit_prog();
    pins(1'b0, 1'b0, 1'b0);
  endtask
endmodule // scp_cfg_master
`default_nettype wire

// [verification/test_scp_readout.sv]
// self-checking bench for the serial memory readout
// assumes: partner model drives all pins; small array keeps the run short
`timescale 1ns/1ps
`default_nettype none
module test_scp_readout;
  localparam int WORDS = 4;
  logic        clk;
  logic        rst_n;
  wire logic   promClk;
  wire logic   chipEnable_n;
  wire logic   resetOe;
  wire logic   vppHigh;
  wire logic   dataIn;
  wire logic   dataOut;
  wire logic   dataOe_n;
  wire logic   cascade_enable_out_n;
  wire logic   lowPower;
  wire logic   progActive;
  int          miscompares;
  int          compares;
  logic [31:0] mem [WORDS];

  scp_cfg_master p (.clk(clk), .promClk(promClk), .chipEnable_n(chipEnable_n),
    .resetOe(resetOe), .vppHigh(vppHigh), .dataIn(dataIn));

  scp_readout #(.WORDS(WORDS)) u_dut (.clk(clk), .rst_n(rst_n), .promClk(promClk),
    .chipEnable_n(chipEnable_n), .resetOe(resetOe), .vppHigh(vppHigh), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe_n(dataOe_n), .cascade_enable_out_n(cascade_enable_out_n),
    .lowPower(lowPower), .progActive(progActive));

  // 25 MHz clock
  initial clk = 1'b0;
  always #20 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic stop_test();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // outputs looked at a small delay after an edge, never on it; covers filter and fetch
  task automatic settle();
    repeat (10) @(posedge clk);
    #1;
  endtask

  // whole array against the model; one pause with ce high mid-word
  task automatic read_all(input logic oe);
    for (int a = 0; a < WORDS; a++)
      for (int b = 0; b < 32; b++)
      begin
        check(32'(dataOut), 32'(mem[a][b]));
        check(32'(dataOe_n), 32'h0);
        if (a == 1 && b == 5)
        begin
          p.pins(1'b1, oe, 1'b0);
          p.step(1'b1);
          settle();
          check(32'({lowPower, dataOe_n, cascade_enable_out_n}), 32'h7);
          p.pins(1'b0, oe, 1'b0);
          settle();
        end
        // released data line wanders while the device drives
        p.step(1'($urandom));
        // filter plus output register put the next bit out a few clk later
        settle();
      end
    settle();
    check(32'({cascade_enable_out_n, dataOe_n}), 32'h1);
  endtask

  initial
  begin
    void'($urandom(32'hBB0E));
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    check(32'({progActive, dataOe_n, cascade_enable_out_n}), 32'h3);
    p.enter_prog();
    settle();
    check(32'({progActive, cascade_enable_out_n}), 32'h3);
    for (int a = 0; a < WORDS; a++)
    begin
      mem[a] = $urandom;
      p.write_word(mem[a]);
    end
    // overflow word of zeros: reset becomes active low
    p.write_word(32'h0);
    settle();
    check(32'({cascade_enable_out_n, dataOe_n}), 32'h1);
    p.exit_prog();
    settle();
    check(32'(progActive), 32'h0);
    p.pins(1'b0, 1'b1, 1'b0);
    settle();
    read_all(1'b1);
    // after end of array: follow ce, then clear on reset level
    p.pins(1'b1, 1'b1, 1'b0);
    settle();
    check(32'({cascade_enable_out_n, lowPower}), 32'h3);
    p.pins(1'b0, 1'b1, 1'b0);
    settle();
    check(32'(cascade_enable_out_n), 32'h0);
    p.pins(1'b0, 1'b0, 1'b0);
    settle();
    check(32'({cascade_enable_out_n, dataOe_n}), 32'h3);
    p.pins(1'b0, 1'b1, 1'b0);
    settle();
    read_all(1'b1);
    // back into programming: polarity still active low, then step to overflow
    p.enter_prog();
    settle();
    check(32'({progActive, cascade_enable_out_n}), 32'h2);
    for (int a = 0; a < WORDS; a++)
    begin
      p.pins(1'b1, 1'b0, 1'b0);
      p.step(1'b0);
    end
    // all-ones overflow word: reset becomes active high
    p.write_word(32'hFFFF_FFFF);
    settle();
    check(32'({progActive, cascade_enable_out_n}), 32'h3);
    p.exit_prog();
    settle();
    // reset pin grounded for good: reads run, position is never cleared
    read_all(1'b0);
    p.step(1'b0);
    settle();
    check(32'({cascade_enable_out_n, dataOe_n}), 32'h1);
    stop_test();
  end

  // watchdog: run needs about 10200 clk, limit at 50000
  initial
  begin
    #2000000;
    miscompares++;
    stop_test();
  end
endmodule // test_scp_readout
`default_nettype wire
